// file: src/dli_params.svh
`ifndef DLI_PARAMS_SVH
`define DLI_PARAMS_SVH
// ==========================================
// Register byte offsets
`define DLI_ADR_CTRL 8'h00
`define DLI_ADR_STA 8'h04
`define DLI_ADR_STB 8'h08
`define DLI_ADR_TADR 8'h0C
`define DLI_ADR_TDATA 8'h10
`define DLI_ADR_GO 8'h14
// ==========================================
// Control fields
`define DLI_CTL_EN 0
`define DLI_CTL_SWAI 1
`define DLI_CTL_IE 2
`define DLI_TMO_LSB 8
`define DLI_TMO_RST 8'h10
// ==========================================
// Status and go fields
`define DLI_STA_ERR 0
`define DLI_STA_PARITY_FAULT_FLAG 1
`define DLI_STA_TERR 2
`define DLI_STA_TIME 3
`define DLI_STA_CNCL 4
`define DLI_STA_PAR_LSB 8
`define DLI_STB_ATT 0
`define DLI_STB_BUSY 1
`define DLI_STB_SLEEP 2
`define DLI_GO_RNW 0
// ==========================================
// Link commands and acknowledge byte
`define DLI_CMD_IDLE 8'h00
`define DLI_CMD_WRITE 8'h5A
`define DLI_CMD_READ 8'hA5
`define DLI_ACKB_ACK 0
`define DLI_ACKB_ERR 1
`define DLI_ACKB_PAR_LSB 2
// ==========================================
// Timing
`define DLI_SYS_PERIOD_NS 10
`define DLI_LINK_PERIOD_NS 160
`endif

// file: src/dli_pkg.sv
package dli_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADR = 3'b010,
    ST_DATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK = 3'b101
  } dli_state_type;

  typedef logic [7:0] dli_byte_type;

  // Replaceable two-bit parity, shared with the target model
  function automatic logic [1:0] dli_parity(input dli_byte_type cmd,
      input dli_byte_type adr, input dli_byte_type dat);
    return {^dat, ^{cmd, adr}};
  endfunction
endpackage

// file: src/dli_ack_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dli_ack_if;
  logic [7:0] ack_byte;
  logic [1:0] exp_par;
  logic check;
  logic ack_seen;
  logic par_bad;
  logic terr;
  logic [1:0] rx_par;
  modport main (output ack_byte, exp_par, check, input ack_seen, par_bad, terr, rx_par);
  modport chk (input ack_byte, exp_par, check, output ack_seen, par_bad, terr, rx_par);
endinterface
`default_nettype wire

// file: src/dli_ack_check.sv
`timescale 1ns/1ns
`default_nettype none
`include "dli_params.svh"
module dli_ack_check (
  dli_ack_if.chk bus
);
  // ==========================================
  // Acknowledge byte decode
  assign bus.rx_par = bus.ack_byte[`DLI_ACKB_PAR_LSB +: 2];
  assign bus.ack_seen = bus.check & bus.ack_byte[`DLI_ACKB_ACK];
  assign bus.par_bad = bus.ack_seen & (bus.rx_par != bus.exp_par);
  assign bus.terr = bus.ack_seen & bus.ack_byte[`DLI_ACKB_ERR];
endmodule // dli_ack_check
`default_nettype wire

// file: src/dli_link_initiator.sv
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "dli_params.svh"
module dli_link_initiator (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic attention_line,
  input wire logic [7:0] link_data_in,
  output logic [7:0] link_data_out,
  output logic link_data_oe,
  output logic link_clock_out,
  output logic gpio_mode,
  output logic clocks_stopped,
  output logic busy,
  output logic attention_irq,
  output logic link_error_irq
);
  localparam int HALF_CYC = `DLI_LINK_PERIOD_NS / (2 * `DLI_SYS_PERIOD_NS);

  // ==========================================
  // Pin synchronisers
  logic [8:0] pin_in;
  logic [8:0] rx_bits;
  logic att_s;
  logic [7:0] rx_byte;

  assign pin_in = {attention_line, link_data_in};

  generate
    for (genvar i = 0; i < 9; i++) begin : g_sync
      logic s1_r;
      logic s2_r;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
        end
      end
      assign rx_bits[i] = s2_r;
    end
  endgenerate

  assign att_s = rx_bits[8];
  assign rx_byte = rx_bits[7:0];

  // ==========================================
  // State declarations
  dli_pkg::dli_state_type state_r;
  logic clk_r;
  logic [7:0] div_r;
  logic ack_r;
  logic [31:0] dat_o_r;
  logic en_r;
  logic swai_r;
  logic ie_r;
  logic [7:0] tmo_r;
  logic [7:0] tmo_cnt_r;
  logic [7:0] adr_buf_r;
  logic [7:0] dat_buf_r;
  logic [7:0] cmd_r;
  logic [7:0] dout_r;
  logic oe_r;
  logic rnw_r;
  logic sleep_r;
  logic err_r;
  logic parity_fault_flag_r;
  logic terr_r;
  logic timeout_flag_r;
  logic cncl_r;
  logic [1:0] par_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ==========================================
  // Wishbone slave
  logic acc;
  logic go_req;
  logic can_start;
  logic stall;
  logic wr_fire;
  logic go_fire;
  logic [31:0] rd_nxt;

  assign acc = wb_cyc_i & wb_stb_i;
  assign go_req = acc & wb_we_i & hit(wb_adr_i, `DLI_ADR_GO);
  assign can_start = (state_r == dli_pkg::ST_IDLE) & ~clk_r & ~sleep_r;
  // Blocking start: hold the acknowledge until the link is free
  assign stall = go_req & en_r & ~can_start;
  assign wr_fire = acc & wb_we_i & ack_r;
  assign go_fire = go_req & ack_r & en_r & wb_sel_i[0];

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= acc & ~ack_r & ~stall;
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit(wb_adr_i, `DLI_ADR_CTRL)) begin
      rd_nxt[`DLI_CTL_EN] = en_r;
      rd_nxt[`DLI_CTL_SWAI] = swai_r;
      rd_nxt[`DLI_CTL_IE] = ie_r;
      rd_nxt[`DLI_TMO_LSB +: 8] = tmo_r;
    end else if (hit(wb_adr_i, `DLI_ADR_STA)) begin
      rd_nxt[`DLI_STA_ERR] = err_r;
      rd_nxt[`DLI_STA_PARITY_FAULT_FLAG] = parity_fault_flag_r;
      rd_nxt[`DLI_STA_TERR] = terr_r;
      rd_nxt[`DLI_STA_TIME] = timeout_flag_r;
      rd_nxt[`DLI_STA_CNCL] = cncl_r;
      rd_nxt[`DLI_STA_PAR_LSB +: 2] = par_r;
    end else if (hit(wb_adr_i, `DLI_ADR_STB)) begin
      rd_nxt[`DLI_STB_ATT] = att_s;
      rd_nxt[`DLI_STB_BUSY] = busy;
      rd_nxt[`DLI_STB_SLEEP] = sleep_r;
    end else if (hit(wb_adr_i, `DLI_ADR_TADR)) begin
      rd_nxt[7:0] = adr_buf_r;
    end else if (hit(wb_adr_i, `DLI_ADR_TDATA)) begin
      rd_nxt[7:0] = dat_buf_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      dat_o_r <= 32'h0000_0000;
    else if (acc & ~ack_r & ~wb_we_i)
      dat_o_r <= rd_nxt;
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_o_r;

  // ==========================================
  // Control register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      swai_r <= 1'b0;
      ie_r <= 1'b0;
      tmo_r <= `DLI_TMO_RST;
    end else if (wr_fire & hit(wb_adr_i, `DLI_ADR_CTRL)) begin
      if (wb_sel_i[0]) begin
        // Enable is write-once; only reset clears it
        en_r <= en_r | wb_dat_i[`DLI_CTL_EN];
        swai_r <= wb_dat_i[`DLI_CTL_SWAI];
        ie_r <= wb_dat_i[`DLI_CTL_IE];
      end
      if (wb_sel_i[1])
        tmo_r <= wb_dat_i[`DLI_TMO_LSB +: 8];
    end
  end

  // ==========================================
  // Link clock divider
  logic run;
  logic tick;
  logic fall;

  // Runs during a frame; once idle it only finishes a high phase
  assign run = en_r & ~sleep_r & ((state_r != dli_pkg::ST_IDLE) | clk_r);
  assign tick = run & (div_r == 8'(HALF_CYC - 1));
  assign fall = tick & clk_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_r <= 8'h00;
      clk_r <= 1'b0;
    end else if (!run) begin
      div_r <= 8'h00;
    end else if (tick) begin
      div_r <= 8'h00;
      clk_r <= ~clk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ==========================================
  // Acknowledge check
  dli_ack_if ack_bus ();
  logic ack_seen;
  logic par_ev;
  logic terr_ev;
  logic tmo_ev;

  assign ack_bus.ack_byte = rx_byte;
  assign ack_bus.check = fall & (state_r == dli_pkg::ST_ACK);
  assign ack_bus.exp_par = dli_pkg::dli_parity(cmd_r, adr_buf_r, dat_buf_r);
  assign ack_seen = ack_bus.ack_seen;
  assign par_ev = ack_bus.par_bad;
  assign terr_ev = ack_bus.terr;
  assign tmo_ev = ack_bus.check & ~ack_seen & (tmo_cnt_r >= tmo_r);

  dli_ack_check u_ack_check (
    .bus(ack_bus.chk)
  );

  // ==========================================
  // Transaction sequencer
  logic [7:0] start_cmd;
  logic start_rnw;

  assign start_rnw = wb_dat_i[`DLI_GO_RNW];
  // A frozen link sends only the idle command
  assign start_cmd = err_r ? `DLI_CMD_IDLE :
                     (start_rnw ? `DLI_CMD_READ : `DLI_CMD_WRITE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= dli_pkg::ST_IDLE;
      cmd_r <= `DLI_CMD_IDLE;
      dout_r <= 8'h00;
      oe_r <= 1'b0;
      rnw_r <= 1'b0;
      tmo_cnt_r <= 8'h00;
    end else if (go_fire) begin
      state_r <= dli_pkg::ST_CMD;
      rnw_r <= start_rnw;
      cmd_r <= start_cmd;
      dout_r <= start_cmd;
      oe_r <= 1'b1;
    end else if (fall) begin
      case (state_r)
        dli_pkg::ST_CMD: begin
          if (cmd_r == `DLI_CMD_IDLE) begin
            state_r <= dli_pkg::ST_IDLE;
            oe_r <= 1'b0;
          end else begin
            state_r <= dli_pkg::ST_ADR;
            dout_r <= adr_buf_r;
          end
        end
        dli_pkg::ST_ADR: begin
          if (rnw_r) begin
            state_r <= dli_pkg::ST_RDATA;
            oe_r <= 1'b0;
          end else begin
            state_r <= dli_pkg::ST_DATA;
            dout_r <= dat_buf_r;
          end
        end
        dli_pkg::ST_DATA: begin
          state_r <= dli_pkg::ST_ACK;
          oe_r <= 1'b0;
          tmo_cnt_r <= 8'h00;
        end
        dli_pkg::ST_RDATA: begin
          state_r <= dli_pkg::ST_ACK;
          tmo_cnt_r <= 8'h00;
        end
        dli_pkg::ST_ACK: begin
          if (ack_seen | tmo_ev)
            state_r <= dli_pkg::ST_IDLE;
          else
            tmo_cnt_r <= tmo_cnt_r + 8'h01;
        end
        default: begin
          state_r <= dli_pkg::ST_IDLE;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Address and data buffers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      adr_buf_r <= 8'h00;
      dat_buf_r <= 8'h00;
    end else if (!err_r) begin
      if (wr_fire & wb_sel_i[0] & (state_r == dli_pkg::ST_IDLE)) begin
        if (hit(wb_adr_i, `DLI_ADR_TADR))
          adr_buf_r <= wb_dat_i[7:0];
        if (hit(wb_adr_i, `DLI_ADR_TDATA))
          dat_buf_r <= wb_dat_i[7:0];
      end
      if (fall & (state_r == dli_pkg::ST_RDATA))
        dat_buf_r <= rx_byte;
    end
  end

  // ==========================================
  // Error flags
  logic err_clr;

  assign err_clr = wr_fire & wb_sel_i[0] & hit(wb_adr_i, `DLI_ADR_STA) &
                   wb_dat_i[`DLI_STA_ERR];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      err_r <= 1'b0;
      parity_fault_flag_r <= 1'b0;
      terr_r <= 1'b0;
      timeout_flag_r <= 1'b0;
      cncl_r <= 1'b0;
      par_r <= 2'h0;
    end else begin
      // Later assignments win, so a new error beats the clear
      if (err_clr) begin
        err_r <= 1'b0;
        parity_fault_flag_r <= 1'b0;
        terr_r <= 1'b0;
        timeout_flag_r <= 1'b0;
        cncl_r <= 1'b0;
      end
      if (par_ev) begin
        err_r <= 1'b1;
        parity_fault_flag_r <= 1'b1;
        par_r <= ack_bus.rx_par;
      end
      if (terr_ev) begin
        err_r <= 1'b1;
        terr_r <= 1'b1;
      end
      if (tmo_ev) begin
        err_r <= 1'b1;
        timeout_flag_r <= 1'b1;
      end
      if (go_fire & err_r)
        cncl_r <= 1'b1;
    end
  end

  // ==========================================
  // Low power
  logic lp_req;

  assign lp_req = stop_mode | (wait_mode & swai_r);

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      sleep_r <= 1'b0;
    else if (!lp_req)
      sleep_r <= 1'b0;
    else if (can_start & ~go_req)
      sleep_r <= 1'b1;
  end

  // ==========================================
  // Outputs
  assign link_clock_out = clk_r;
  assign link_data_out = dout_r;
  assign link_data_oe = oe_r;
  assign gpio_mode = ~en_r;
  assign clocks_stopped = ~en_r | sleep_r;
  assign busy = state_r != dli_pkg::ST_IDLE;
  // Not gated by sleep so it can wake the processor
  assign attention_irq = ie_r & en_r & att_s;
  // No local mask beyond the shared enable
  assign link_error_irq = ie_r & en_r & err_r;

  // ==========================================
  // Assertions
  par_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    par_ev |=> err_r && parity_fault_flag_r && par_r == $past(rx_byte[`DLI_ACKB_PAR_LSB +: 2]))
    else $error("parity fault not recorded");

  terr_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    terr_ev |=> err_r && terr_r)
    else $error("target error not recorded");

  tmo_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ack_bus.check && !ack_seen && tmo_cnt_r >= tmo_r) |=>
      err_r && timeout_flag_r && state_r == dli_pkg::ST_IDLE)
    else $error("timeout not flagged");

  disabled_gpio_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !en_r |-> gpio_mode && !link_data_oe && !link_clock_out && clocks_stopped)
    else $error("disabled link not idle");

  swai_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wait_mode && !stop_mode && !swai_r) |=> !sleep_r)
    else $error("wait mode stopped the link");

  stop_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stop_mode && state_r == dli_pkg::ST_IDLE && !clk_r && !go_req) |=> sleep_r)
    else $error("stop mode not entered");

  sleep_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sleep_r |-> !link_clock_out && state_r == dli_pkg::ST_IDLE)
    else $error("clock high while asleep");

  err_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (err_clr && !par_ev && !terr_ev && !tmo_ev) |=> !err_r && !parity_fault_flag_r && !timeout_flag_r)
    else $error("error flags not cleared");

  freeze_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (go_fire && err_r) |=> cmd_r == `DLI_CMD_IDLE && cncl_r ##1 $stable(adr_buf_r))
    else $error("frozen link sent a real command");

  att_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (attention_line && en_r && ie_r) [*3] |-> attention_irq)
    else $error("attention request missing");

  err_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    link_error_irq |-> ie_r && err_r)
    else $error("error request without enable");

  write_done_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ack_seen && !rnw_r);
  read_done_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ack_seen && rnw_r);
  sleep_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(sleep_r));
  timeout_c: cover property (@(posedge sys_clk) disable iff (!rst_n) tmo_ev);
endmodule // dli_link_initiator
`default_nettype wire

// file: verif/dli_target_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "dli_params.svh"
// ==========================================
// Companion-die target, behavioural
module dli_target_model (
  input wire logic sys_clk,
  input wire logic link_clock_out,
  input wire logic [7:0] link_data_lines,
  input wire logic ack_en,
  input wire logic err_en,
  input wire logic par_flip,
  input wire logic att_req,
  input wire logic [7:0] rd_byte,
  output logic [7:0] tgt_out,
  output logic tgt_oe,
  output logic attention_line,
  output logic [7:0] cap_cmd,
  output logic [7:0] cap_adr,
  output logic [7:0] cap_dat
);
  int slot = 0;
  int low_cnt = 100;
  logic [1:0] par;
  logic [7:0] pdat;
  assign attention_line = att_req;
  assign pdat = (cap_cmd == `DLI_CMD_READ) ? rd_byte : cap_dat;
  assign par = dli_pkg::dli_parity(cap_cmd, cap_adr, pdat) ^ {1'b0, par_flip};
  initial begin
    tgt_out = 8'h00;
    tgt_oe = 1'b0;
    cap_cmd = 8'h00;
    cap_adr = 8'h00;
    cap_dat = 8'h00;
  end
  always @(posedge sys_clk) low_cnt <= link_clock_out ? 0 : low_cnt + 1;
  // A long low gap marks a new frame, so no sync handshake is needed
  always @(posedge link_clock_out) begin
    // In-frame low phase is 8 cycles; even back-to-back frames leave 10
    slot = (low_cnt > 8) ? 1 : slot + 1;
    if (slot == 1) cap_cmd = link_data_lines;
    if (slot == 2) cap_adr = link_data_lines;
    if (slot == 3 && cap_cmd == `DLI_CMD_WRITE) cap_dat = link_data_lines;
  end
  // Released lines fall to the permanent pull-down
  always @(negedge link_clock_out) begin
    tgt_oe = 1'b0;
    if (slot == 2 && cap_cmd == `DLI_CMD_READ) begin
      tgt_out = rd_byte;
      tgt_oe = 1'b1;
    end
    if (slot == 3 && ack_en && (cap_cmd == `DLI_CMD_WRITE || cap_cmd == `DLI_CMD_READ)) begin
      tgt_out = {4'h0, par, err_en, 1'b1};
      tgt_oe = 1'b1;
    end
  end
endmodule // dli_target_model
`default_nettype wire

// file: verif/dli_link_initiator_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dli_params.svh"
module dli_link_initiator_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, wb_dat_o;
  logic wait_mode = 1'b0, stop_mode = 1'b0;
  logic ack_en = 1'b1, err_en = 1'b0, par_flip = 1'b0, att_req = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] link_data_out, link_wire, tgt_out, cap_cmd, cap_adr, cap_dat;
  logic wb_ack_o, link_data_oe, link_clock_out, gpio_mode, clocks_stopped;
  logic busy, attention_irq, link_error_irq, tgt_oe, attention_line;
  int err_count = 0;
  int checked = 0;
  // Initiator wins, then target, else pull-down
  assign link_wire = link_data_oe ? link_data_out : (tgt_oe ? tgt_out : 8'h00);
  dli_link_initiator u_dli_link_initiator (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .attention_line(attention_line), .link_data_in(link_wire),
    .link_data_out(link_data_out), .link_data_oe(link_data_oe),
    .link_clock_out(link_clock_out), .gpio_mode(gpio_mode),
    .clocks_stopped(clocks_stopped), .busy(busy), .attention_irq(attention_irq),
    .link_error_irq(link_error_irq));
  dli_target_model u_dli_target_model (.sys_clk(sys_clk), .link_clock_out(link_clock_out),
    .link_data_lines(link_wire), .ack_en(ack_en), .err_en(err_en), .par_flip(par_flip),
    .att_req(att_req), .rd_byte(rd_byte), .tgt_out(tgt_out), .tgt_oe(tgt_oe),
    .attention_line(attention_line), .cap_cmd(cap_cmd), .cap_adr(cap_adr),
    .cap_dat(cap_dat));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 3000);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 3000) err_count++;
  endtask
  task automatic start(input logic r, input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, `DLI_ADR_TADR, {24'h0, a});
    wb(1'b1, `DLI_ADR_TDATA, {24'h0, d});
    wb(1'b1, `DLI_ADR_GO, {31'h0, r});
  endtask
  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) err_count++;
  endtask
  task automatic go(input logic r, input logic [7:0] a, input logic [7:0] d);
    start(r, a, d);
    idle();
  endtask
  task automatic clear_err(input logic [1:0] par);
    wb(1'b1, `DLI_ADR_STA, 32'h1);
    wb(1'b0, `DLI_ADR_STA, 32'h0);
    // Received parity is a record, not a flag, so it survives the clear
    chk(q, {22'h0, par, 8'h00});
    chk(link_error_irq, 1'b0);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_after_reset();
    chk({gpio_mode, clocks_stopped, link_clock_out, link_data_oe}, 4'hC);
    wb(1'b0, `DLI_ADR_CTRL, 32'h0);
    chk(q, 32'h1000);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, `DLI_ADR_CTRL, 32'h1005);
    repeat (3) @(posedge sys_clk);
    chk({gpio_mode, clocks_stopped}, 2'b00);
  endtask
  task automatic t_write_read();
    start(1'b0, 8'h3C, 8'hA7);
    // Second start while busy must hold its acknowledge until the first frame ends
    wb(1'b1, `DLI_ADR_GO, 32'h0);
    chk({cap_cmd, cap_dat}, 16'h5AA7);
    idle();
    chk({cap_cmd, cap_adr, cap_dat}, 24'h5A3CA7);
    chk(link_clock_out, 1'b0);
    rd_byte = 8'h96;
    go(1'b1, 8'h55, 8'h00);
    chk({cap_cmd, cap_adr}, 16'hA555);
    wb(1'b0, `DLI_ADR_TDATA, 32'h0);
    chk(q, 32'h96);
    wb(1'b0, `DLI_ADR_STA, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_target_err();
    err_en = 1'b1;
    go(1'b0, 8'h21, 8'h4B);
    err_en = 1'b0;
    wb(1'b0, `DLI_ADR_STA, 32'h0);
    chk(q & 32'h1F, 32'h05);
    chk(link_error_irq, 1'b1);
    go(1'b0, 8'h22, 8'h11);
    chk(cap_cmd, 8'h00);
    wb(1'b0, `DLI_ADR_STA, 32'h0);
    chk(q & 32'h1F, 32'h15);
    wb(1'b0, `DLI_ADR_TDATA, 32'h0);
    chk(q, 32'h4B);
    clear_err(2'b00);
  endtask
  task automatic t_parity();
    logic [1:0] exp_par;
    exp_par = {^8'hC3, ^{8'h5A, 8'h0F}} ^ 2'b01;
    par_flip = 1'b1;
    go(1'b0, 8'h0F, 8'hC3);
    par_flip = 1'b0;
    wb(1'b0, `DLI_ADR_STA, 32'h0);
    chk(q, {22'h0, exp_par, 8'h03});
    clear_err(exp_par);
  endtask
  task automatic t_timeout();
    ack_en = 1'b0;
    go(1'b0, 8'h30, 8'h01);
    ack_en = 1'b1;
    wb(1'b0, `DLI_ADR_STA, 32'h0);
    chk(q & 32'h1F, 32'h09);
    clear_err(2'b01);
  endtask
  task automatic t_attention();
    att_req <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(attention_irq, 1'b1);
    wb(1'b0, `DLI_ADR_STB, 32'h0);
    chk(q & 32'h3, 32'h1);
    stop_mode <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({clocks_stopped, link_clock_out, attention_irq}, 3'b101);
    stop_mode <= 1'b0;
    att_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({clocks_stopped, attention_irq}, 2'b00);
    wb(1'b0, `DLI_ADR_STB, 32'h0);
    chk(q & 32'h1, 32'h0);
  endtask
  task automatic t_wait();
    wait_mode <= 1'b1;
    go(1'b0, 8'h44, 8'h5E);
    chk({cap_dat, 7'h0, clocks_stopped}, 16'h5E00);
    wait_mode <= 1'b0;
    wb(1'b1, `DLI_ADR_CTRL, 32'h1007);
    start(1'b0, 8'h66, 8'h99);
    repeat (20) @(posedge sys_clk);
    wait_mode <= 1'b1;
    idle();
    chk({cap_adr, cap_dat}, 16'h6699);
    repeat (4) @(posedge sys_clk);
    chk({clocks_stopped, link_clock_out}, 2'b10);
    repeat (40) @(posedge sys_clk);
    chk(link_clock_out, 1'b0);
    wait_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(clocks_stopped, 1'b0);
  endtask
  task automatic t_mask();
    wb(1'b1, `DLI_ADR_CTRL, 32'h1001);
    att_req <= 1'b1;
    err_en = 1'b1;
    go(1'b0, 8'h12, 8'h34);
    err_en = 1'b0;
    chk({attention_irq, link_error_irq}, 2'b00);
    wb(1'b0, `DLI_ADR_STA, 32'h0);
    chk(q & 32'h1, 32'h1);
    att_req <= 1'b0;
    clear_err(2'b01);
  endtask
  task automatic t_reset_abort();
    start(1'b0, 8'h70, 8'h0F);
    repeat (20) @(posedge sys_clk);
    chk(busy, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk({busy, link_data_oe, link_clock_out, gpio_mode}, 4'h1);
    wb(1'b0, `DLI_ADR_CTRL, 32'h0);
    chk(q, 32'h1000);
  endtask
  // ==========================================
  // Verdict
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_after_reset();
    t_write_read();
    t_target_err();
    t_parity();
    t_timeout();
    t_attention();
    t_wait();
    t_mask();
    t_reset_abort();
    finish_test();
  end
endmodule // dli_link_initiator_tb
`default_nettype wire
